// file: scc_conv.sv
module scc_conv
  import scc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic has_track_hold,
  input wire logic conv_clk_pin,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic comp_above,
  output scc_out_t dout
);
  logic [1:0] clk_s_q, cs_s_q, rd_s_q, th_s_q;
  logic clk_prev_q, clk_prev_d;
  logic div_q, div_d;
  logic [3:0] icnt_q, icnt_d;
  logic [1:0] fall_q, fall_d;
  scc_state_t st_q, st_d;
  logic [RES_BITS-1:0] sar_q, sar_d, bit_q, bit_d;
  scc_out_t out_q, out_d;
  logic pin_fall, start, int_tick;

  // clock, strobe and track/hold pins cross into sys_clk through two flops before anything reads them; comp_above is read directly
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_s_q <= 2'b11;
      cs_s_q <= 2'b11;
      rd_s_q <= 2'b11;
      th_s_q <= 2'b00;
    end else if (clk_en) begin
      clk_s_q <= {clk_s_q[0], conv_clk_pin};
      cs_s_q <= {cs_s_q[0], cs_n};
      rd_s_q <= {rd_s_q[0], rd_n};
      th_s_q <= {th_s_q[0], has_track_hold};
    end
  end

  assign pin_fall = clk_prev_q & ~clk_s_q[1];
  assign start = ~cs_s_q[1] & ~rd_s_q[1];
  // the divided clock ticks on every second falling edge of the pin
  assign int_tick = pin_fall & div_q;

  always_comb begin
    clk_prev_d = clk_s_q[1];
    div_d = div_q;
    icnt_d = icnt_q;
    fall_d = fall_q;
    st_d = st_q;
    sar_d = sar_q;
    bit_d = bit_q;
    out_d = out_q;
    out_d.sample_pulse = 1'b0;
    unique case (st_q)
      SCC_IDLE: begin
        // clock pin edges are ignored here and the oscillator is clamped
        out_d.osc_clamp = 1'b1;
        out_d.sample_switch = 1'b1;
        div_d = 1'b0;
        if (start) begin
          st_d = SCC_TRACK;
          fall_d = 2'b00;
          icnt_d = 4'h0;
          sar_d = RES_ZERO;
          bit_d = BIT_MSB;
          out_d.busy_n = 1'b0;
          out_d.osc_clamp = 1'b0;
          out_d.sample_switch = 1'b1;
        end
      end
      SCC_TRACK, SCC_CONV: begin
        if (pin_fall) begin
          div_d = ~div_q;
          if (fall_q != HOLD_EDGE) begin
            fall_d = fall_q + 2'b01;
          end
          // third falling edge opens the switch, two full cycles after the strobes
          if (th_s_q[1] && fall_q == HOLD_EDGE - 2'b01) begin
            out_d.sample_switch = 1'b0;
          end
        end
        if (int_tick) begin
          if (icnt_q == 4'h0) begin
            st_d = SCC_CONV;
          end
          if (bit_q != RES_ZERO) begin
            // one decision per internal cycle, msb first
            if (comp_above) begin
              sar_d = sar_q | bit_q;
            end
            bit_d = bit_q >> 1;
            if (!th_s_q[1]) begin
              out_d.sample_pulse = 1'b1;
            end
          end
          icnt_d = icnt_q + 4'h1;
          if (icnt_q == DIV_LAST) begin
            st_d = SCC_IDLE;
            out_d.busy_n = 1'b1;
            out_d.result = (comp_above && bit_q != RES_ZERO) ? (sar_q | bit_q) : sar_q;
            out_d.sample_switch = 1'b1;
            out_d.osc_clamp = 1'b1;
          end
        end
      end
      default: st_d = SCC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_prev_q <= 1'b1;
      div_q <= 1'b0;
      icnt_q <= 4'h0;
      fall_q <= 2'b00;
      st_q <= SCC_IDLE;
      sar_q <= RES_ZERO;
      bit_q <= RES_ZERO;
      out_q <= '{busy_n: 1'b1, sample_switch: 1'b1, osc_clamp: 1'b1,
                 sample_pulse: 1'b0, result: RES_ZERO};
    end else if (clk_en) begin
      clk_prev_q <= clk_prev_d;
      div_q <= div_d;
      icnt_q <= icnt_d;
      fall_q <= fall_d;
      st_q <= st_d;
      sar_q <= sar_d;
      bit_q <= bit_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

  // start and end of a conversion
  a_busy_falls_start: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && st_q == SCC_IDLE && start) |=> (!out_q.busy_n && !out_q.osc_clamp))
    else $error("busy not lowered at conversion start");

  a_busy_ends_high: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && st_q != SCC_IDLE && st_d == SCC_IDLE) |=> out_q.busy_n)
    else $error("busy not released at conversion end");

  a_result_held: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !(st_q != SCC_IDLE && st_d == SCC_IDLE) |=> $stable(out_q.result))
    else $error("result changed outside a conversion end");

  // sample switch timing
  a_track_at_start: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && st_q == SCC_IDLE && start) |=> out_q.sample_switch)
    else $error("switch open at conversion start");

  a_hold_on_third: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && st_q != SCC_IDLE && pin_fall && fall_q == 2'b10 && th_s_q[1]) |=> !out_q.sample_switch)
    else $error("hold not taken on third falling edge");

  a_hold_kept: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!out_q.sample_switch && !(st_q != SCC_IDLE && st_d == SCC_IDLE)) |=> !out_q.sample_switch)
    else $error("switch closed before conversion end");

  a_track_two_cycles: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (out_q.sample_switch && !out_q.busy_n && fall_q < 2'b10) |=> out_q.sample_switch)
    else $error("switch opened too early");

  a_retrack_at_end: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(out_q.busy_n) |-> out_q.sample_switch)
    else $error("switch not closed at end");

  // sampling without track/hold
  a_sample_no_th: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    out_q.sample_pulse |-> (!th_s_q[1] && !out_q.busy_n))
    else $error("stray sample pulse");

  a_pulse_single: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && out_q.sample_pulse) |=> !out_q.sample_pulse)
    else $error("sample pulse longer than one cycle");

  // divided clock and conversion length
  a_div_toggles: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && st_q != SCC_IDLE && pin_fall) |=> (div_q != $past(div_q)))
    else $error("divider missed a pin falling edge");

  a_count_bound: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q != SCC_IDLE) |-> icnt_q <= DIV_LAST)
    else $error("conversion longer than ten internal cycles");

  // idle behaviour: pin ignored, oscillator clamped
  a_clamp_idle: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == SCC_IDLE && !$past(start)) |-> out_q.osc_clamp)
    else $error("oscillator running while idle");

  a_div_idle_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && st_q == SCC_IDLE) |=> (!div_q && !out_q.sample_pulse))
    else $error("internal clock active while idle");

  // approximation order
  a_sar_msb_first: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && st_q != SCC_IDLE && int_tick && bit_q != RES_ZERO) |=> (bit_q == ($past(bit_q) >> 1)))
    else $error("decision bit not stepped msb first");

  // a low clock enable must freeze every output
  a_freeze_hold: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !clk_en |=> ($stable(out_q) && $stable(st_q)))
    else $error("state moved while clock enable low");
endmodule : scc_conv

// file: scc_pkg.sv
package scc_pkg;
  localparam int RES_BITS = 8;
  // conversion length in clock-pin cycles and in divided cycles
  localparam int CONV_PIN_CYCLES = 20;
  localparam int CONV_INT_CYCLES = CONV_PIN_CYCLES / 2;
  // hold taken on this falling edge of the clock pin after the strobes go low
  localparam logic [1:0] HOLD_EDGE = 2'h3;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [3:0] DIV_LAST = 4'(CONV_INT_CYCLES - 1);
  localparam logic [RES_BITS-1:0] RES_ZERO = 8'h00;
  localparam logic [RES_BITS-1:0] BIT_MSB = 8'h80;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_TRACK = 2'b01,
    SCC_CONV = 2'b10
  } scc_state_t;

  typedef struct packed {
    logic busy_n;
    logic sample_switch;
    logic osc_clamp;
    logic sample_pulse;
    logic [RES_BITS-1:0] result;
  } scc_out_t;
endpackage : scc_pkg

// file: scc_host.sv
module scc_host (
  input wire logic sys_clk,
  input wire logic busy_n,
  output logic cs_n,
  output logic rd_n,
  output logic conv_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    conv_clk_pin = 1'b1;
  end
  // free-running pin clock: may keep running between conversions
  always #30 conv_clk_pin = ~conv_clk_pin;
  // lower just after a pin rise so no pin fall races the strobe sync
  task automatic start();
    @(posedge conv_clk_pin);
    @(posedge sys_clk);
    #1;
    cs_n = 1'b0;
    rd_n = 1'b0;
  endtask : start
  always @(posedge sys_clk) begin
    if (!cs_n && busy_n === 1'b0) begin
      #1;
      cs_n = 1'b1;
      rd_n = 1'b1;
    end
  end
endmodule : scc_host

// file: tb_sar_conversion_clock_sampling.sv
module tb_sar_conversion_clock_sampling import scc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, clk_en, has_track_hold, comp_above;
  logic conv_clk_pin, cs_n, rd_n;
  scc_out_t dout;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  scc_conv i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .has_track_hold(has_track_hold), .conv_clk_pin(conv_clk_pin), .cs_n(cs_n),
    .rd_n(rd_n), .comp_above(comp_above), .dout(dout));
  scc_host i_host (.sys_clk(sys_clk), .busy_n(dout.busy_n), .cs_n(cs_n), .rd_n(rd_n),
    .conv_clk_pin(conv_clk_pin));
  always #4 sys_clk = ~sys_clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  // falls are pin falls seen since the strobes went low
  task automatic run_conv(input logic th, input logic comp, input logic [7:0] exp_res);
    int falls, hold_at, pulses, low_at;
    logic pin_q;
    has_track_hold = th;
    comp_above = comp;
    i_host.start();
    {falls, hold_at, pulses, low_at} = '0;
    pin_q = conv_clk_pin;
    for (int cyc = 1; cyc < 400; cyc++) begin
      @(posedge sys_clk);
      #1;
      if (pin_q && !conv_clk_pin) falls++;
      pin_q = conv_clk_pin;
      if (dout.busy_n === 1'b0 && low_at == 0) low_at = cyc;
      if (dout.sample_switch === 1'b0 && hold_at == 0) hold_at = falls;
      if (dout.sample_pulse === 1'b1) pulses++;
      check(dout.osc_clamp === dout.busy_n, "clamp not tied to busy");
      if (low_at != 0 && dout.busy_n === 1'b1) break;
    end
    check(low_at >= 3 && low_at <= 4, "busy start latency");
    check(falls == CONV_PIN_CYCLES, "conversion length");
    check(hold_at == (th ? 3 : 0), "hold instant");
    check(pulses == (th ? 0 : RES_BITS), "sample count");
    check(dout.result === exp_res, "result");
    check(dout.sample_switch === 1'b1, "not tracking after end");
  endtask : run_conv
  // clock enable low in mid-conversion freezes everything, then the conversion completes
  task automatic freeze_check();
    scc_out_t snap;
    comp_above = 1'b0;
    i_host.start();
    repeat (6) @(posedge sys_clk);
    #1;
    clk_en = 1'b0;
    snap = dout;
    repeat (40) @(posedge sys_clk);
    #1;
    check(dout === snap, "state moved while clock enable low");
    clk_en = 1'b1;
    repeat (300) @(posedge sys_clk);
    #1;
    check(dout.busy_n === 1'b1 && dout.result === 8'h00, "conversion lost after freeze");
  endtask : freeze_check
  initial begin
    {sys_clk, sys_rst, clk_en, has_track_hold, comp_above} = 5'h1e;
    repeat (5) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check(dout === {4'he, RES_ZERO}, "reset values");
    run_conv(1'b1, 1'b1, 8'hff);
    run_conv(1'b1, 1'b0, 8'h00);
    run_conv(1'b0, 1'b1, 8'hff);
    // pin keeps toggling while idle and must start nothing
    repeat (60) @(posedge sys_clk);
    #1;
    check(dout.busy_n === 1'b1 && dout.result === 8'hff, "idle disturbed");
    freeze_check();
    tally_and_finish();
  end
endmodule : tb_sar_conversion_clock_sampling
